/* common/smc_cfg_params.svh */
// Register offsets, field positions, reset values and the page offset base width.
`ifndef SMC_CFG_PARAMS_SVH
`define SMC_CFG_PARAMS_SVH

// Register offsets (byte addresses on the plain register port).
`define OFS_PULSE 8'h04
`define OFS_CYCLE 8'h08
`define OFS_MODE 8'h0c
`define OFS_STATUS 8'h10

// Pulse register fields.
`define F_SEL_PULSE_HI 30
`define F_SEL_PULSE_LO 24
`define F_STB_PULSE_HI 22
`define F_STB_PULSE_LO 16

// Cycle register fields.
`define F_WR_CYC_HI 8
`define F_WR_CYC_LO 0
`define F_RD_CYC_HI 24
`define F_RD_CYC_LO 16

// Mode register fields.
`define F_RD_CTRL 0
`define F_WR_CTRL 1
`define F_HOLD_HI 5
`define F_HOLD_LO 4
`define F_BYTE_TYPE 8
`define F_WIDTH_HI 13
`define F_WIDTH_LO 12
`define F_FLOAT_HI 19
`define F_FLOAT_LO 16
`define F_FLOAT_OPT 20
`define F_PAGE_EN 24
`define F_PAGE_SZ_HI 29
`define F_PAGE_SZ_LO 28

// Reset values.
`define RST_PULSE 32'h0101_0101
`define RST_CYCLE 32'h0003_0003
`define RST_MODE 32'h0000_1003

// Page offset base width: a 4-byte page has two offset bits.
`define PAGE_BASE_BITS 2

`endif

/* common/smc_cfg_pkg.sv */
// Types shared by the static memory cycle engine.
package smc_cfg_pkg;
    // Access engine states, Gray coded along idle, pulse, hold.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_PULSE = 2'b01,
        ST_HOLD  = 2'b11
    } state_t;

    // External hold handling modes.
    typedef enum logic [1:0] {
        HOLD_OFF    = 2'b00,
        HOLD_RSVD   = 2'b01,
        HOLD_FROZEN = 2'b10,
        HOLD_READY  = 2'b11
    } hold_mode_t;

    // External data bus widths.
    typedef enum logic [1:0] {
        BW_8    = 2'b00,
        BW_16   = 2'b01,
        BW_32   = 2'b10,
        BW_RSVD = 2'b11
    } bus_width_t;
endpackage

/* core/phase_timer.sv */
// Loadable down counter that times one phase of an access.
`timescale 1ns/1ps
`default_nettype none
module phase_timer #(
    parameter int W = 10
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         run,
    output logic      [W-1:0] count
);
    // Load wins over run; the count rests at zero.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count <= '0;
        end else if (load) begin
            count <= load_val;
        end else if (run && count != '0) begin
            count <= count - W'(1);
        end
    end
endmodule
`default_nettype wire

/* core/cycle_length_config_engine.sv */
// Static memory access engine for one chip select with its timing registers.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "smc_cfg_params.svh"
module cycle_length_config_engine #(
    parameter int AW = 26,
    parameter int DW = 32
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [31:0]                 reg_rdata,
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire logic                        req_write,
    input  wire logic [AW-1:0]               req_addr,
    input  wire logic [3:0]                  req_be,
    input  wire logic [DW-1:0]               req_wdata,
    output logic                             rsp_valid,
    output logic      [DW-1:0]               rsp_rdata,
    output logic                             chip_select_n,
    output logic                             read_strobe_n,
    output logic                             write_strobe_n,
    output logic      [3:0]                  byte_write_strobe_n,
    output logic      [3:0]                  byte_select_n,
    output logic      [AW-1:0]               mem_addr,
    output logic      [DW-1:0]               mem_dout,
    output logic                             mem_doe,
    input  wire logic [DW-1:0]               mem_din,
    input  wire logic                        ext_hold_request_n,
    output logic                             float_busy
);
    import smc_cfg_pkg::*;

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [31:0] pulse_stage_q;  // Pulse values as last written.
    logic [31:0] cycle_stage_q;  // Cycle values as last written.
    logic [31:0] pulse_act_q;    // Pulse values in force.
    logic [31:0] cycle_act_q;    // Cycle values in force.
    logic [31:0] mode_q;         // Mode values, in force on write.
    logic [31:0] reg_rdata_q;    // Read data, one cycle after the strobe.
    logic        mode_wr;        // Software writes the mode register.

    assign mode_wr = reg_wr && reg_addr == `OFS_MODE;

    // Timing writes are only staged; the mode write moves them into force,
    // so an access never runs on a half-written set of timings.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pulse_stage_q <= `RST_PULSE;
            cycle_stage_q <= `RST_CYCLE;
        end else if (reg_wr && reg_addr == `OFS_PULSE) begin
            pulse_stage_q <= reg_wdata;
        end else if (reg_wr && reg_addr == `OFS_CYCLE) begin
            cycle_stage_q <= reg_wdata;
        end
    end

    // Apply staged timings together with the mode value.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pulse_act_q <= `RST_PULSE;
            cycle_act_q <= `RST_CYCLE;
            mode_q      <= `RST_MODE;
        end else if (mode_wr) begin
            pulse_act_q <= pulse_stage_q;
            cycle_act_q <= cycle_stage_q;
            mode_q      <= reg_wdata;
        end
    end

    // ****************************************************************
    // Field decode
    // ****************************************************************
    logic [6:0]  sel_pulse_f;   // Read select pulse length field.
    logic [6:0]  stb_pulse_f;   // Read strobe pulse length field.
    logic [8:0]  wr_cyc_f;      // Write cycle length field.
    logic [8:0]  rd_cyc_f;      // Read cycle length field.
    hold_mode_t  hold_mode;     // External hold handling.
    bus_width_t  bus_width;     // External data width.
    logic        byte_wr_type;  // One write strobe per byte lane.
    logic [3:0]  float_cyc;     // Data float time in cycles.
    logic        float_opt;     // Float optimization enable.
    logic        page_en;       // Page-mode reads.
    logic [1:0]  page_sel;      // Page size code.

    assign sel_pulse_f  = pulse_act_q[`F_SEL_PULSE_HI:`F_SEL_PULSE_LO];
    assign stb_pulse_f  = pulse_act_q[`F_STB_PULSE_HI:`F_STB_PULSE_LO];
    assign wr_cyc_f     = cycle_act_q[`F_WR_CYC_HI:`F_WR_CYC_LO];
    assign rd_cyc_f     = cycle_act_q[`F_RD_CYC_HI:`F_RD_CYC_LO];
    assign hold_mode    = hold_mode_t'(mode_q[`F_HOLD_HI:`F_HOLD_LO]);
    assign bus_width    = bus_width_t'(mode_q[`F_WIDTH_HI:`F_WIDTH_LO]);
    assign byte_wr_type = mode_q[`F_BYTE_TYPE];
    assign float_cyc    = mode_q[`F_FLOAT_HI:`F_FLOAT_LO];
    assign float_opt    = mode_q[`F_FLOAT_OPT];
    assign page_en      = mode_q[`F_PAGE_EN];
    assign page_sel     = mode_q[`F_PAGE_SZ_HI:`F_PAGE_SZ_LO];

    // Pulse length is 256 * bit 6 plus bits 5:0, never below one cycle.
    function automatic logic [8:0] pulse_len(input logic [6:0] f);
        logic [8:0] v;
        v = {f[6], 2'b00, f[5:0]};
        pulse_len = (v == 9'h000) ? 9'h001 : v;
    endfunction

    // Cycle length is 256 * bits 8:7 plus bits 6:0.
    function automatic logic [9:0] cycle_len(input logic [8:0] f);
        cycle_len = {f[8:7], 1'b0, f[6:0]};
    endfunction

    // Address with the offset inside the page cleared.
    function automatic logic [AW-1:0] page_base(input logic [AW-1:0] a,
                                                input logic [1:0] ps);
        logic [AW-1:0] m;
        m = {AW{1'b1}} << (`PAGE_BASE_BITS + ps);
        page_base = a & m;
    endfunction

    // ****************************************************************
    // Access setup
    // ****************************************************************
    state_t        state_q;      // Access engine state.
    logic          write_q;      // Current access is a write.
    logic          page_rd_q;    // Current access is a page-mode read.
    logic [3:0]    be_q;         // Byte enables of the current access.
    logic [AW-1:0] addr_q;       // Address of the current access.
    logic [DW-1:0] wdata_q;      // Write data of the current access.
    logic          page_vld_q;   // A page is open on this chip select.
    logic [AW-1:0] page_tag_q;   // Base address of the open page.
    logic          accept;       // A request is taken this cycle.
    logic          page_hit;     // Request lies in the open page.
    logic [9:0]    wr_total;     // Write cycle length.
    logic [9:0]    rd_total;     // Read cycle length.
    logic [8:0]    pulse_ld;     // Pulse phase length for the request.
    logic [9:0]    hold_ld;      // Hold phase length for the request.

    assign wr_total = cycle_len(wr_cyc_f);
    assign rd_total = cycle_len(rd_cyc_f);
    assign page_hit = page_en && page_vld_q
                      && page_base(req_addr, page_sel) == page_tag_q;

    // Split each access into a pulse phase and a hold phase. A write of two
    // cycles or more keeps a hold cycle so the data stays valid past the strobe's rise.
    always_comb begin
        pulse_ld = 9'h001;
        hold_ld  = 10'h000;
        if (req_write) begin
            // The pulse timer is nine bits wide, so a write of 512 cycles
            // or more moves the excess into the hold phase.
            if (wr_total > 10'h1ff) begin
                pulse_ld = 9'h1ff;
                hold_ld  = wr_total - 10'h1ff;
            end else if (wr_total > 10'h001) begin
                pulse_ld = wr_total[8:0] - 9'h001;
                hold_ld  = 10'h001;
            end
        end else if (page_en) begin
            // Page reads ignore the cycle length and carry no hold phase.
            pulse_ld = page_hit ? pulse_len(stb_pulse_f)
                                : pulse_len(sel_pulse_f);
        end else begin
            pulse_ld = pulse_len(sel_pulse_f);
            if (rd_total > {1'b0, pulse_ld}) begin
                hold_ld = rd_total - {1'b0, pulse_ld};
            end
        end
    end

    // Without optimization a new access waits out the whole float time;
    // with it the next access may start, its setup overlapping the float.
    assign req_ready = state_q == ST_IDLE && !(float_busy && !float_opt);
    assign accept    = req_valid && req_ready;

    // Latch the request.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            write_q   <= 1'b0;
            page_rd_q <= 1'b0;
            be_q      <= 4'h0;
            addr_q    <= '0;
            wdata_q   <= '0;
        end else if (accept) begin
            write_q   <= req_write;
            page_rd_q <= !req_write && page_en;
            be_q      <= req_be;
            addr_q    <= req_addr;
            wdata_q   <= req_wdata;
        end
    end

    // ****************************************************************
    // External inputs and timers
    // ****************************************************************
    logic          hold_meta_q;  // First stage of the hold synchroniser.
    logic          hold_low_q;   // Hold request, synchronised.
    logic [DW-1:0] din_meta_q;   // First stage of the data synchroniser.
    logic [DW-1:0] din_sync_q;   // Read data, synchronised.

    // Both pins are asynchronous to clk_sys. The two-stage delay means the
    // data taken at the pulse end were sampled two cycles earlier, so a
    // read pulse shorter than three cycles returns stale data.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hold_meta_q <= 1'b0;
            hold_low_q  <= 1'b0;
            din_meta_q  <= '0;
            din_sync_q  <= '0;
        end else begin
            hold_meta_q <= !ext_hold_request_n;
            hold_low_q  <= hold_meta_q;
            din_meta_q  <= mem_din;
            din_sync_q  <= din_meta_q;
        end
    end

    logic [8:0] pulse_cnt;   // Pulse cycles left.
    logic [9:0] hold_cnt;    // Hold cycles left.
    logic [4:0] float_cnt;   // Bus-busy cycles left after a read.
    logic       freeze;      // Frozen mode stalls the pulse.
    logic       extend;      // Ready mode extends the pulse end.
    logic       pulse_run;   // Pulse phase advances.
    logic       pulse_end;   // Last pulse cycle completes.
    logic       finish;      // Access completes this cycle.
    logic       read_done;   // Read control signal rises next edge.

    // The hold request is looked at only in the pulse phase.
    assign freeze    = state_q == ST_PULSE && hold_mode == HOLD_FROZEN
                       && hold_low_q;
    assign extend    = state_q == ST_PULSE && hold_mode == HOLD_READY
                       && hold_low_q && pulse_cnt == 9'h001;
    assign pulse_run = state_q == ST_PULSE && !freeze && !extend;
    assign pulse_end = pulse_run && pulse_cnt == 9'h001;
    assign finish    = (pulse_end && hold_cnt == 10'h000)
                       || (state_q == ST_HOLD && hold_cnt == 10'h001);
    assign read_done = pulse_end && !write_q;

    phase_timer #(.W(9)) u_pulse (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .load     (accept),
        .load_val (pulse_ld),
        .run      (pulse_run),
        .count    (pulse_cnt)
    );

    phase_timer #(.W(10)) u_hold (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .load     (accept),
        .load_val (hold_ld),
        .run      (state_q == ST_HOLD),
        .count    (hold_cnt)
    );

    // Strobe and select rise together here, so the float window opens at
    // the rise of whichever signal controls the read.
    phase_timer #(.W(5)) u_float (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .load     (read_done),
        .load_val ({1'b0, float_cyc} + 5'h01),
        .run      (1'b1),
        .count    (float_cnt)
    );

    assign float_busy = float_cnt != 5'h00;

    // ****************************************************************
    // Access sequencing
    // ****************************************************************
    // Idle, pulse, then an optional hold phase.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        state_q <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (pulse_end) begin
                        state_q <= (hold_cnt == 10'h000) ? ST_IDLE : ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (hold_cnt == 10'h001) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Track the open page; any write, standard read or mode change
    // closes it so the next page read takes the long first access.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            page_vld_q <= 1'b0;
            page_tag_q <= '0;
        end else if (read_done && page_rd_q) begin
            // Opening wins over a clear in the same cycle.
            page_vld_q <= 1'b1;
            page_tag_q <= page_base(addr_q, page_sel);
        end else if (mode_wr || (accept && (req_write || !page_en))) begin
            page_vld_q <= 1'b0;
        end
    end

    // Capture read data at the pulse end and answer on completion.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= finish;
            if (read_done) begin
                rsp_rdata <= din_sync_q;
            end
        end
    end

    // ****************************************************************
    // Memory pins
    // ****************************************************************
    logic active;   // Pulse phase of any access.
    logic wide;     // Byte lanes are meaningful.

    assign active = state_q == ST_PULSE;
    assign wide   = bus_width == BW_16 || bus_width == BW_32;

    // Page reads keep select and strobe low together for the whole pulse.
    assign chip_select_n  = !active;
    assign read_strobe_n  = !(active && !write_q);
    assign write_strobe_n = !(active && write_q
                              && !(wide && byte_wr_type));
    assign byte_write_strobe_n = (active && write_q && wide && byte_wr_type)
                                 ? ~be_q : 4'hf;
    assign byte_select_n  = (active && wide && !byte_wr_type)
                                 ? ~be_q : 4'hf;
    assign mem_addr = addr_q;
    assign mem_dout = wdata_q;
    assign mem_doe  = write_q && state_q != ST_IDLE;

    // ****************************************************************
    // Register read port
    // ****************************************************************
    // Unmapped offsets read as zero.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFS_PULSE:  reg_rdata_q <= pulse_stage_q;
                `OFS_CYCLE:  reg_rdata_q <= cycle_stage_q;
                `OFS_MODE:   reg_rdata_q <= mode_q;
                `OFS_STATUS: reg_rdata_q <= {28'h0, page_vld_q, float_busy,
                                             state_q != ST_IDLE, hold_low_q};
                default:     reg_rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic [8:0] exp_pulse_q;  // Pulse length loaded for this access.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            exp_pulse_q <= 9'h000;
        end else if (accept) begin
            exp_pulse_q <= pulse_ld;
        end
    end

    sequence s_pulse_last_low;
        state_q == ST_PULSE && hold_mode == HOLD_READY
            && pulse_cnt == 9'h001 && hold_low_q;
    endsequence

    a_ready_extend: assert property (s_pulse_last_low |=> state_q == ST_PULSE)
        else $error("ready hold did not extend the pulse");
    a_frozen_stall: assert property (freeze |=> $stable(pulse_cnt) && $stable(hold_cnt))
        else $error("frozen hold did not stall the access");
    a_hold_ignored: assert property (state_q == ST_PULSE && hold_mode == HOLD_OFF
            && pulse_cnt > 9'h001 |=> pulse_cnt == $past(pulse_cnt) - 9'h001)
        else $error("disabled hold input changed the pulse");
    a_float_length: assert property (read_done |=> float_cnt == {1'b0, $past(float_cyc)} + 5'h01)
        else $error("float window length wrong");
    a_float_gate: assert property (float_busy && !float_opt && state_q == ST_IDLE
            |=> state_q == ST_IDLE)
        else $error("access started inside float time");
    a_stage_only: assert property (reg_wr && reg_addr == `OFS_PULSE |=> $stable(pulse_act_q))
        else $error("timing applied without mode write");
    a_byte_write: assert property (active && write_q && wide && byte_wr_type
            |-> write_strobe_n && byte_write_strobe_n == ~be_q)
        else $error("byte write strobes wrong");
    a_std_pulse: assert property (accept && !req_write && !page_en
            |=> pulse_cnt == pulse_len(sel_pulse_f))
        else $error("read select pulse length wrong");
    a_page_hit: assert property (accept && page_hit && !req_write
            |=> exp_pulse_q == pulse_len(stb_pulse_f))
        else $error("page hit did not use strobe pulse");
endmodule
`default_nettype wire

/* verif/mem_model.sv */
// Behavioural static memory with a wait request that the bench can arm.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input  wire logic        clk_sys,
    input  wire logic        chip_select_n,
    input  wire logic [25:0] mem_addr,
    input  wire logic [3:0]  hold_len,
    output logic      [31:0] mem_din,
    output logic             ext_hold_request_n
);
    logic cs_q = 1'b1; // Select seen one edge ago.
    int   n    = 0;    // Cycles left with the wait request low.
    // Deselected, the bus shows the inverse, so stale data cannot pass for a match.
    assign mem_din = chip_select_n ? ~{6'h0, mem_addr} : {6'h0, mem_addr} ^ 32'h5a5a_0000;
    // The wait request starts one cycle into the pulse and lasts hold_len cycles.
    always @(posedge clk_sys) begin
        cs_q <= chip_select_n;
        if (cs_q && !chip_select_n) n <= hold_len;
        else if (n > 0) n <= n - 1;
    end
    assign ext_hold_request_n = !(n > 0);
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the static memory cycle engine.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, req_valid = 0, req_write = 0;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, req_wdata = 0, reg_rdata, rsp_rdata, mem_dout, mem_din;
    logic [25:0] req_addr = 0, mem_addr;
    logic [3:0] req_be = 4'hf, hold_len = 0, byte_write_strobe_n, byte_select_n, bw, bs, nb;
    logic req_ready, rsp_valid, chip_select_n, read_strobe_n, write_strobe_n, mem_doe;
    logic ext_hold_request_n, float_busy, ws, rf;
    int err_total = 0, num_checks = 0, fb = 0, tick = 0;
    cycle_length_config_engine dut_u (.*);
    mem_model mem_u (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    // Float window length, and whether a request could be taken inside it.
    always @(negedge clk_sys) if (float_busy === 1'b1) begin
        fb++;
        rf |= req_ready;
    end
    always @(posedge clk_sys) begin
        tick++;
        if (tick == 20000) begin
            err_total++;
            end_of_test;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        num_checks++;
        if (g !== x) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, x, "reg");
    endtask
    // One access; counts cycles from the taking edge to the response.
    task automatic acc(input logic w, input logic [25:0] a, input int e);
        int c = 0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= $urandom;
        @(negedge clk_sys);
        while (req_ready !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        {bw, bs, ws} = 9'h1ff;
        do begin
            @(negedge clk_sys);
            c++;
            if (!chip_select_n) begin
                {bw, bs, ws} &= {byte_write_strobe_n, byte_select_n, write_strobe_n};
                chk({read_strobe_n, mem_doe, mem_addr}, {w, w, a}, "pins");
                if (w) chk(mem_dout, req_wdata, "wr data");
            end
        end while (rsp_valid !== 1'b1 && c < 600);
        chk(c, e, "cycles");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        int p, c, e, t;
        logic [31:0] a;
        logic [8:0] wl[3] = '{9'h002, 9'h009, 9'h081};
        void'($urandom(32'h84a67c7b));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rreg(8'h08, 32'h0003_0003);
        rreg(8'h20, 32'h0);
        wreg(8'h08, 32'h0000_0009);
        acc(1'b1, 26'h0, 4);
        foreach (wl[i]) begin
            wreg(8'h08, {23'h0, wl[i]});
            wreg(8'h0c, 32'h0000_1003);
            acc(1'b1, 26'h0, wl[i][8:7] * 256 + wl[i][6:0] + 1);
        end
        for (int i = 0; i < 5; i++) begin
            p = (i == 4) ? 32'h41 : $urandom_range(3, 6);
            c = $urandom_range(1, 10);
            a = $urandom_range(0, 1023);
            wreg(8'h04, p << 24);
            wreg(8'h08, c << 16);
            wreg(8'h0c, 32'h0000_1003);
            e = p[6] * 256 + p[5:0];
            acc(1'b0, a[25:0], (e > c ? e : c) + 1);
            chk(rsp_rdata, a ^ 32'h5a5a_0000, "data");
        end
        $display("timing test done");
        wreg(8'h04, 32'h0300_0000);
        wreg(8'h08, 32'h0004_0004);
        for (int k = 0; k < 12; k++) begin
            wreg(8'h0c, {18'h0, k[3:2], 3'h0, k[1], 8'h03});
            req_be <= 4'($urandom_range(1, 15));
            acc(k[0], 26'h0, 5);
            nb = ~req_be;
            e = (k[3:2] != 0);
            chk(bw, (e && k[1] && k[0]) ? nb : 4'hf, "byte wr");
            chk(bs, (e && !k[1]) ? nb : 4'hf, "byte sel");
            chk(ws, !(k[0] && !(e && k[1])), "wr strobe");
        end
        for (int k = 0; k < 4; k++) begin
            t = $urandom_range(1, 15);
            wreg(8'h0c, {11'h0, k[0], t[3:0], 15'h0801, k[1]});
            fb = 0;
            rf = 0;
            acc(1'b0, 26'h0, 5);
            repeat (20) @(negedge clk_sys);
            chk(fb, t + 1, "float");
            chk(rf, k[0], "float opt");
        end
        $display("bus test done");
        wreg(8'h04, 32'h0400_0000);
        wreg(8'h08, 32'h0005_0005);
        for (int k = 0; k < 3; k++) begin
            wreg(8'h0c, {26'h0, k ? 2'(k + 1) : 2'h0, 4'h3});
            hold_len <= 4'h3;
            acc(1'b0, 26'h0, k ? 9 : 6);
            hold_len <= 4'h0;
        end
        wreg(8'h04, 32'h0502_0000);
        for (int k = 0; k < 4; k++) begin
            wreg(8'h0c, {2'h0, k[1:0], 3'h0, 1'b1, 24'h00_1003});
            c = 4 << k;
            acc(1'b0, 26'h40, 6);
            acc(1'b0, 26'(64 + c - 1), 3);
            acc(1'b0, 26'(64 + c), 6);
        end
        $display("hold and page test done");
        end_of_test;
    end
endmodule
`default_nettype wire
